//--- jtg_tap_top.v
// Boundary-scan test access port: controller, instruction and data regs
`timescale 1ns/1ps
`include "jtg_consts.vh"

module jtg_tap_top
(
   input  wire                  mclk,
   input  wire                  resetn,
   input  wire                  test_clock_in,
   input  wire                  test_mode_select_in,
   input  wire                  test_serial_in,
   input  wire                  test_reset_in_n,
   input  wire [`JTG_BSR_W-1:0] bscan_pins_in,
   output reg                   test_serial_out,
   output reg                   test_serial_out_oe,
   output wire [`JTG_IR_W-1:0]  instr_out,
   output wire [`JTG_ID_W-1:0]  idcode_out,
   output wire [`JTG_BSR_W-1:0] bscan_out,
   output reg                   pins_from_bscan,
   output reg                   pins_hiz,
   output reg  [15:0]           tap_state
);

   // ****************************************************************
   // Controller states, one-hot
   // ****************************************************************
   localparam [15:0] ST_TLR    = 16'h0001;
   localparam [15:0] ST_RTI    = 16'h0002;
   localparam [15:0] ST_SEL_DR = 16'h0004;
   localparam [15:0] ST_CAP_DR = 16'h0008;
   localparam [15:0] ST_SH_DR  = 16'h0010;
   localparam [15:0] ST_EX1_DR = 16'h0020;
   localparam [15:0] ST_PAU_DR = 16'h0040;
   localparam [15:0] ST_EX2_DR = 16'h0080;
   localparam [15:0] ST_UPD_DR = 16'h0100;
   localparam [15:0] ST_SEL_IR = 16'h0200;
   localparam [15:0] ST_CAP_IR = 16'h0400;
   localparam [15:0] ST_SH_IR  = 16'h0800;
   localparam [15:0] ST_EX1_IR = 16'h1000;
   localparam [15:0] ST_PAU_IR = 16'h2000;
   localparam [15:0] ST_EX2_IR = 16'h4000;
   localparam [15:0] ST_UPD_IR = 16'h8000;

   // Identification code assembled from its fields
   localparam [`JTG_ID_W-1:0] ID_CODE = {`JTG_ID_VERSION, `JTG_ID_PART,
                                         `JTG_ID_MAKER, `JTG_ID_LSB};

   // ****************************************************************
   // Declarations
   // ****************************************************************
   wire [`JTG_SYNC_W-1:0] pin_sync;
   wire                   tck_s;
   wire                   tms_s;
   wire                   tdi_s;
   reg                    tck_d_r;
   wire                   tck_rise;
   wire                   tck_fall;
   reg  [15:0]            tap_state_nxt;
   wire [1:0]             dr_sel;
   wire [`JTG_IR_W-1:0]   ir_shift;
   wire                   ir_sout;
   wire                   id_sout;
   wire                   bsr_sout;
   reg                    byp_r;
   reg                    tdo_nxt;
   wire                   in_tlr;
   wire                   ir_cap;
   wire                   ir_shift_en;
   wire                   ir_upd;
   wire                   dr_cap;
   wire                   dr_shift;
   wire                   dr_upd;
   wire [`JTG_IR_W-1:0]   ir_new;

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Next controller state from present state and mode select
   function [15:0] tap_next;
      input [15:0] st;
      input        tms;
      begin
         case (st)
            ST_TLR    : tap_next = tms ? ST_TLR    : ST_RTI;
            ST_RTI    : tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR : tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR : tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR  : tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR : tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR : tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR : tap_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR : tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR : tap_next = tms ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR : tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR  : tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR : tap_next = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR : tap_next = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR : tap_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR : tap_next = tms ? ST_SEL_DR : ST_RTI;
            default   : tap_next = ST_TLR;
         endcase
      end
   endfunction

   // Data register selected by an instruction code
   function [1:0] sel_of;
      input [`JTG_IR_W-1:0] op;
      begin
         case (op)
            `JTG_OP_SAMPLE : sel_of = `JTG_SEL_BSR;
            `JTG_OP_EXTEST : sel_of = `JTG_SEL_BSR;
            `JTG_OP_BYPASS : sel_of = `JTG_SEL_BYP;
            `JTG_OP_CLAMP  : sel_of = `JTG_SEL_BYP;
            `JTG_OP_HIGHZ  : sel_of = `JTG_SEL_BYP;
            `JTG_OP_IDCODE : sel_of = `JTG_SEL_ID;
            default        : sel_of = `JTG_SEL_BYP;
         endcase
      end
   endfunction

   // ****************************************************************
   // Pin synchronisers and test clock edge detection
   // ****************************************************************
   jtg_sync
   #(
      .W (`JTG_SYNC_W)
   )
   u_sync
   (
      .mclk   (mclk),
      .resetn (resetn),
      .d      ({test_serial_in, test_mode_select_in, test_clock_in}),
      .q      (pin_sync)
   );

   assign tck_s = pin_sync[0];
   assign tms_s = pin_sync[1];
   assign tdi_s = pin_sync[2];

   // Delayed copy of the synchronised clock
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         tck_d_r <= 1'b0;
      else
         tck_d_r <= tck_s;
   end

   // Mode select and serial input share the clock's delay
   assign tck_rise = tck_s & ~tck_d_r;
   assign tck_fall = ~tck_s & tck_d_r;

   // ****************************************************************
   // Controller state register
   // ****************************************************************
   always @*
   begin
      tap_state_nxt = tap_state;
      if (tck_rise)
         tap_state_nxt = tap_next(tap_state, tms_s);
   end

   // Both resets force the reset state
   always @(posedge mclk or negedge resetn or negedge test_reset_in_n)
   begin
      if (!resetn || !test_reset_in_n)
         tap_state <= ST_TLR;
      else
         tap_state <= tap_state_nxt;
   end

   // ****************************************************************
   // Per-state strobes
   // ****************************************************************
   assign in_tlr      = (tap_state == ST_TLR);
   assign ir_cap      = tck_rise & (tap_state == ST_CAP_IR);
   assign ir_shift_en = tck_rise & (tap_state == ST_SH_IR);
   assign ir_upd      = tck_fall & (tap_state == ST_UPD_IR);
   assign dr_cap      = tck_rise & (tap_state == ST_CAP_DR);
   assign dr_shift    = tck_rise & (tap_state == ST_SH_DR);
   assign dr_upd      = tck_fall & (tap_state == ST_UPD_DR);

   // Current instruction picks the data register
   assign dr_sel = sel_of(instr_out);

   // ****************************************************************
   // Instruction register
   // ****************************************************************
   jtg_shreg
   #(
      .W       (`JTG_IR_W),
      .RST_VAL (`JTG_OP_IDCODE)
   )
   u_ir
   (
      .mclk            (mclk),
      .resetn          (resetn),
      .test_reset_in_n (test_reset_in_n),
      .cap_en          (ir_cap),
      .shift_en        (ir_shift_en),
      .upd_en          (ir_upd),
      .force_en        (in_tlr),
      .sin             (tdi_s),
      .cap_val         (`JTG_IR_CAPTURE),
      .sout            (ir_sout),
      .shift_r         (ir_shift),
      .par_r           (instr_out)
   );

   // ****************************************************************
   // Identification register
   // ****************************************************************
   jtg_shreg
   #(
      .W       (`JTG_ID_W),
      .RST_VAL (ID_CODE)
   )
   u_id
   (
      .mclk            (mclk),
      .resetn          (resetn),
      .test_reset_in_n (test_reset_in_n),
      .cap_en          (dr_cap & (dr_sel == `JTG_SEL_ID)),
      .shift_en        (dr_shift & (dr_sel == `JTG_SEL_ID)),
      .upd_en          (dr_upd & (dr_sel == `JTG_SEL_ID)),
      .force_en        (in_tlr),
      .sin             (tdi_s),
      .cap_val         (ID_CODE),
      .sout            (id_sout),
      .shift_r         (),
      .par_r           (idcode_out)
   );

   // ****************************************************************
   // Boundary scan register
   // ****************************************************************
   jtg_shreg
   #(
      .W       (`JTG_BSR_W),
      .RST_VAL ({`JTG_BSR_W{1'b0}})
   )
   u_bsr
   (
      .mclk            (mclk),
      .resetn          (resetn),
      .test_reset_in_n (test_reset_in_n),
      .cap_en          (dr_cap & (dr_sel == `JTG_SEL_BSR)),
      .shift_en        (dr_shift & (dr_sel == `JTG_SEL_BSR)),
      .upd_en          (dr_upd & (dr_sel == `JTG_SEL_BSR)),
      .force_en        (1'b0),
      .sin             (tdi_s),
      .cap_val         (bscan_pins_in),
      .sout            (bsr_sout),
      .shift_r         (),
      .par_r           (bscan_out)
   );

   // ****************************************************************
   // Bypass stage
   // ****************************************************************
   always @(posedge mclk or negedge resetn or negedge test_reset_in_n)
   begin
      if (!resetn || !test_reset_in_n)
         byp_r <= 1'b0;
      else if (dr_cap && (dr_sel == `JTG_SEL_BYP))
         byp_r <= 1'b0;
      else if (dr_shift && (dr_sel == `JTG_SEL_BYP))
         byp_r <= tdi_s;
   end

   // ****************************************************************
   // Pin control flags, taken with the new instruction
   // ****************************************************************
   assign ir_new = ir_shift;

   // Flags change only when the instruction latch changes
   always @(posedge mclk or negedge resetn or negedge test_reset_in_n)
   begin
      if (!resetn || !test_reset_in_n)
      begin
         pins_from_bscan <= 1'b0;
         pins_hiz        <= 1'b0;
      end
      else if (in_tlr)
      begin
         pins_from_bscan <= 1'b0;
         pins_hiz        <= 1'b0;
      end
      else if (ir_upd)
      begin
         pins_from_bscan <= (ir_new == `JTG_OP_EXTEST) |
                            (ir_new == `JTG_OP_CLAMP);
         pins_hiz        <= (ir_new == `JTG_OP_HIGHZ);
      end
   end

   // ****************************************************************
   // Serial output, changed on the test clock falling edge
   // ****************************************************************
   always @*
   begin
      tdo_nxt = byp_r;
      if (tap_state == ST_SH_IR)
         tdo_nxt = ir_sout;
      else
      begin
         case (dr_sel)
            `JTG_SEL_BSR : tdo_nxt = bsr_sout;
            `JTG_SEL_ID  : tdo_nxt = id_sout;
            default      : tdo_nxt = byp_r;
         endcase
      end
   end

   // Driven only while a register is in the serial path
   always @(posedge mclk or negedge resetn or negedge test_reset_in_n)
   begin
      if (!resetn || !test_reset_in_n)
      begin
         test_serial_out    <= 1'b0;
         test_serial_out_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         test_serial_out_oe <= (tap_state == ST_SH_IR) |
                               (tap_state == ST_SH_DR);
         if ((tap_state == ST_SH_IR) || (tap_state == ST_SH_DR))
            test_serial_out <= tdo_nxt;
      end
   end

endmodule

//--- jtg_consts.vh
// Shared constants for the boundary-scan test access port logic
`ifndef JTG_CONSTS_VH
`define JTG_CONSTS_VH

// ****************************************************************
// Register lengths
// ****************************************************************
`define JTG_IR_W        3
`define JTG_ID_W        32
`define JTG_BSR_W       196

// ****************************************************************
// Instruction codes
// ****************************************************************
`define JTG_OP_EXTEST   3'h0
`define JTG_OP_IDCODE   3'h1
`define JTG_OP_SAMPLE   3'h2
`define JTG_OP_CLAMP    3'h3
`define JTG_OP_HIGHZ    3'h4
`define JTG_OP_BYPASS   3'h7

// Fixed pattern loaded in Capture-IR
`define JTG_IR_CAPTURE  3'h1

// ****************************************************************
// Selected data register codes
// ****************************************************************
`define JTG_SEL_BYP     2'h0
`define JTG_SEL_BSR     2'h1
`define JTG_SEL_ID      2'h2

// ****************************************************************
// Identification code fields (values are arbitrary)
// ****************************************************************
`define JTG_ID_VERSION  4'h1
`define JTG_ID_PART     16'h0a5c
`define JTG_ID_MAKER    11'h2b6
`define JTG_ID_LSB      1'h1

// ****************************************************************
// Synchroniser width: clock, mode select, serial input
// ****************************************************************
`define JTG_SYNC_W      3

`endif

//--- jtg_sync.v
// Two-stage synchroniser bank for the test pins
`timescale 1ns/1ps

module jtg_sync
#(
   parameter W = 1
)
(
   input  wire         mclk,
   input  wire         resetn,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   // ****************************************************************
   // One pair of flip-flops per bit
   // ****************************************************************
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         reg s1_r;
         reg s2_r;
         // First stage feeds only the second
         always @(posedge mclk or negedge resetn)
         begin
            if (!resetn)
            begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end
            else
            begin
               s1_r <= d[i];
               s2_r <= s1_r;
            end
         end
         assign q[i] = s2_r;
      end
   endgenerate

endmodule

//--- jtg_shreg.v
// Test data register: shift stages plus latched parallel output
`timescale 1ns/1ps

module jtg_shreg
#(
   parameter         W       = 8,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
   input  wire         mclk,
   input  wire         resetn,
   input  wire         test_reset_in_n,
   input  wire         cap_en,
   input  wire         shift_en,
   input  wire         upd_en,
   input  wire         force_en,
   input  wire         sin,
   input  wire [W-1:0] cap_val,
   output wire         sout,
   output reg  [W-1:0] shift_r,
   output reg  [W-1:0] par_r
);

   // ****************************************************************
   // Shift path, towards the serial output at bit 0
   // ****************************************************************
   always @(posedge mclk or negedge resetn or negedge test_reset_in_n)
   begin
      if (!resetn || !test_reset_in_n)
         shift_r <= RST_VAL;
      else if (cap_en)
         shift_r <= cap_val;
      else if (shift_en)
         shift_r <= {sin, shift_r[W-1:1]};
   end

   // ****************************************************************
   // Parallel latch, untouched while shifting
   // ****************************************************************
   always @(posedge mclk or negedge resetn or negedge test_reset_in_n)
   begin
      if (!resetn || !test_reset_in_n)
         par_r <= RST_VAL;
      else if (force_en)
         par_r <= RST_VAL;
      else if (upd_en)
         par_r <= shift_r;
   end

   assign sout = shift_r[0];

endmodule

//--- jtg_tap_monitor.sv
// Checker for the boundary-scan test access port outputs
`timescale 1ns/1ps
`include "jtg_consts.vh"

module jtg_tap_monitor
(
   input wire                  mclk,
   input wire                  resetn,
   input wire                  test_clock_in,
   input wire                  test_mode_select_in,
   input wire                  test_serial_in,
   input wire                  test_reset_in_n,
   input wire [`JTG_BSR_W-1:0] bscan_pins_in,
   input wire                  test_serial_out,
   input wire                  test_serial_out_oe,
   input wire [`JTG_IR_W-1:0]  instr_out,
   input wire [`JTG_ID_W-1:0]  idcode_out,
   input wire [`JTG_BSR_W-1:0] bscan_out,
   input wire                  pins_from_bscan,
   input wire                  pins_hiz,
   input wire [15:0]           tap_state
);
   localparam [31:0] ID = {`JTG_ID_VERSION, `JTG_ID_PART, `JTG_ID_MAKER,
                           `JTG_ID_LSB};

   // ****************************************************************
   // Controller and register properties
   // ****************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   a_trst_forces_tlr: assert property (!test_reset_in_n |->
      tap_state == 16'h0001 && instr_out == `JTG_OP_IDCODE)
      else $error("test reset did not force reset state and idcode");
   a_tlr_forces_id: assert property (tap_state[0] [*3] |->
      instr_out == `JTG_OP_IDCODE && idcode_out == ID)
      else $error("reset state without idcode or ID value");
   a_state_onehot: assert property ($onehot(tap_state))
      else $error("controller state not one-hot");
   a_state_on_rise: assert property ($changed(tap_state) &&
      test_reset_in_n && $past(test_reset_in_n) |-> $past(test_clock_in, 2)
      || $past(test_clock_in, 3) || $past(test_clock_in, 4))
      else $error("state moved without a test clock rise");
   a_instr_upd_only: assert property ($changed(instr_out) |->
      tap_state[15] || tap_state[0])
      else $error("instruction changed outside update or reset");
   a_bsr_upd_only: assert property ($changed(bscan_out) |->
      tap_state[8] || tap_state[0])
      else $error("boundary latch changed outside update");
   a_flags_decode: assert property (tap_state[1] |->
      pins_hiz == (instr_out == `JTG_OP_HIGHZ) && pins_from_bscan ==
      (instr_out == `JTG_OP_EXTEST || instr_out == `JTG_OP_CLAMP))
      else $error("pin control flags disagree with instruction");
   a_tdo_in_shift: assert property ($changed(test_serial_out) |->
      tap_state[11] || tap_state[4] || tap_state[0])
      else $error("serial out moved outside a shift state");
   a_enter_shift_ir: assert property ($rose(tap_state[11]) |->
      $past(tap_state[10]) || $past(tap_state[14]))
      else $error("Shift-IR entered from a wrong state");
   a_enter_upd_ir: assert property ($rose(tap_state[15]) |->
      $past(tap_state[12]) || $past(tap_state[14]))
      else $error("Update-IR entered from a wrong state");
   a_leave_sel_ir: assert property ($fell(tap_state[9]) |->
      tap_state[10] || tap_state[0])
      else $error("Select-IR-Scan left to a wrong state");
   a_oe_shift_only: assert property (test_serial_out_oe |->
      tap_state[11] || tap_state[4] || tap_state[12] || tap_state[5])
      else $error("serial out driven outside a shift or exit state");
endmodule

bind jtg_tap_top jtg_tap_monitor i_mon (.mclk(mclk), .resetn(resetn),
   .test_clock_in(test_clock_in), .test_mode_select_in(test_mode_select_in),
   .test_serial_in(test_serial_in), .test_reset_in_n(test_reset_in_n),
   .bscan_pins_in(bscan_pins_in), .test_serial_out(test_serial_out),
   .test_serial_out_oe(test_serial_out_oe), .instr_out(instr_out),
   .idcode_out(idcode_out), .bscan_out(bscan_out),
   .pins_from_bscan(pins_from_bscan), .pins_hiz(pins_hiz),
   .tap_state(tap_state));

//--- jtg_ctl_model.sv
// Model of the external test controller driving the test pins
`timescale 1ns/1ps

module jtg_ctl_model
(
   input  wire mclk,
   output reg  tck,
   output reg  tms,
   output reg  tdi,
   input  wire tdo
);
   // ****************************************************************
   // Test clock stands still low between frames
   // ****************************************************************
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // Half of the 320 ns test clock, landing just after an mclk edge
   task half;
   begin
      repeat (4) @(posedge mclk);
      #1;
   end
   endtask

   // One test clock period; mode and data held across the rise
   task step(input reg m, input reg d, output reg q);
   begin
      tms = m;
      tdi = d;
      half;
      tck = 1'b1;
      half;
      q   = tdo;
      tck = 1'b0;
   end
   endtask
endmodule

//--- jtg_tap_top_tb.sv
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`include "jtg_consts.vh"

module jtg_tap_top_tb;
   localparam [31:0] ID = {`JTG_ID_VERSION, `JTG_ID_PART, `JTG_ID_MAKER,
                           `JTG_ID_LSB};
   localparam [17:0] OPS = {3'h2, 3'h0, 3'h3, 3'h4, 3'h7, 3'h1};
   reg            mclk, resetn, trst_n, q, f, h, b;
   reg  [195:0]   pins_in, exp_bsr, d;
   reg  [31:0]    exp_id, seed;
   reg  [255:0]   exp_q[$], scan_v, e;
   reg            kind_q[$];
   reg  [2:0]     code;
   wire           tck, tms, tdi, tdo, fb, hz, oe, tdo_ln;
   wire [2:0]     instr;
   wire [31:0]    idc;
   wire [195:0]   bsr;
   wire [15:0]    st;
   integer        errors, checks, cyc, t, n;
   event          res_ev;

   jtg_tap_top i_dut (.mclk(mclk), .resetn(resetn), .test_clock_in(tck),
      .test_mode_select_in(tms), .test_serial_in(tdi),
      .test_reset_in_n(trst_n), .bscan_pins_in(pins_in),
      .test_serial_out(tdo), .test_serial_out_oe(oe), .instr_out(instr),
      .idcode_out(idc), .bscan_out(bsr), .pins_from_bscan(fb),
      .pins_hiz(hz), .tap_state(st));
   jtg_ctl_model i_ctl (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo_ln));

   // Released line reads inverted, so an undriven sample cannot pass
   assign tdo_ln = oe ? tdo : ~tdo;

   // ****************************************************************
   // Helpers: random source, notes and comparisons
   // ****************************************************************
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task rnd(output [195:0] v);
      integer k;
   begin
      for (k = 0; k < 7; k = k + 1)
      begin
         seed = lfsr(seed);
         v = {v[163:0], seed};
      end
   end
   endtask

   task cmp_scan(input [255:0] ev, input [255:0] g);
   begin
      checks = checks + 1;
      if (g !== ev)
      begin
         errors = errors + 1;
         $display("CHECK FAILED %0t: scan out %h exp %h", $time, g, ev);
      end
   end
   endtask

   task cmp_port(input [255:0] ev, input [255:0] g);
   begin
      checks = checks + 1;
      if (g !== ev)
      begin
         errors = errors + 1;
         $display("CHECK FAILED %0t: outputs %h exp %h", $time, g, ev);
      end
   end
   endtask

   // Expected outputs are queued once the link has settled
   task note_port(input [15:0] s, input [2:0] i, input fe, input he);
   begin
      repeat (8) @(posedge mclk);
      #1;
      exp_q.push_back({7'h0, exp_id, exp_bsr, s, i, fe, he});
      kind_q.push_back(1'b1);
      -> res_ev;
      #1;
   end
   endtask

   task note_scan(input [255:0] ev, input integer len);
   begin
      exp_q.push_back(ev & ((256'h1 << len) - 256'h1));
      kind_q.push_back(1'b0);
      -> res_ev;
      #1;
   end
   endtask

   // Full scan from Run-Test-Idle, optionally pausing after one bit
   task scan(input ir, input [195:0] din, input integer len, input pz);
      integer k;
   begin
      scan_v = 256'h0;
      i_ctl.step(1'b1, ~din[0], q);
      if (ir)
         i_ctl.step(1'b1, ~din[0], q);
      i_ctl.step(1'b0, ~din[0], q);
      i_ctl.step(1'b0, ~din[0], q);
      for (k = 0; k < len; k = k + 1)
      begin
         i_ctl.step((k == len - 1) || (pz && k == 0), din[k], q);
         scan_v[k] = q;
         if (pz && k == 0)
         begin
            i_ctl.step(1'b0, ~din[1], q);
            i_ctl.step(1'b0, ~din[1], q);
            i_ctl.step(1'b1, ~din[1], q);
            i_ctl.step(1'b0, ~din[1], q);
         end
      end
      i_ctl.step(1'b1, din[0], q);
      i_ctl.step(1'b0, din[0], q);
   end
   endtask

   task wrap_up;
   begin
      $display("Comparisons %0d, mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask

   // ****************************************************************
   // Clock, watchdog, result watcher and main sequence
   // ****************************************************************
   initial
   begin
      mclk = 1'b0;
      forever
         #20 mclk = ~mclk;
   end

   // Hang guard, well above the expected run of some 4550 cycles
   always @(posedge mclk)
   begin
      cyc = cyc + 1;
      if (cyc == 30000)
      begin
         errors = errors + 1;
         $display("CHECK FAILED %0t: run did not finish", $time);
         wrap_up;
      end
   end

   // Oldest note against what the design shows now
   initial
   begin
      forever
      begin
         @(res_ev);
         if (kind_q.pop_front())
            cmp_port(exp_q.pop_front(),
               {7'h0, idc, bsr, st, instr, fb, hz});
         else
            cmp_scan(exp_q.pop_front(), scan_v);
      end
   end

   initial
   begin
      errors = 0;
      checks = 0;
      cyc = 0;
      seed = 32'h58fa3308;
      resetn = 1'b0;
      trst_n = 1'b1;
      pins_in = 196'h0;
      exp_bsr = 196'h0;
      exp_id = ID;
      repeat (6) @(posedge mclk);
      #1;
      resetn = 1'b1;
      note_port(16'h0001, `JTG_OP_IDCODE, 1'b0, 1'b0);
      $display("Reset state done");
      i_ctl.step(1'b0, 1'b0, q);
      for (t = 0; t < 6; t = t + 1)
      begin
         code = OPS[3 * (5 - t) +: 3];
         f = (code == `JTG_OP_EXTEST) || (code == `JTG_OP_CLAMP);
         h = (code == `JTG_OP_HIGHZ);
         b = (code == `JTG_OP_EXTEST) || (code == `JTG_OP_SAMPLE);
         n = b ? 196 : (code == `JTG_OP_IDCODE) ? 32 : 8;
         rnd(pins_in);
         rnd(d);
         scan(1'b1, {193'h0, code}, 3, t == 1);
         note_scan(256'h1, 3);
         note_port(16'h0002, code, f, h);
         scan(1'b0, d, n, 1'b0);
         e = b ? {60'h0, pins_in} : (code == `JTG_OP_IDCODE) ?
             {224'h0, ID} : {248'h0, d[6:0], 1'b0};
         note_scan(e, n);
         if (b)
            exp_bsr = d;
         if (code == `JTG_OP_IDCODE)
            exp_id = d[31:0];
         note_port(16'h0002, code, f, h);
         $display("Instruction %h done", code);
      end
      i_ctl.step(1'b1, 1'b0, q);
      i_ctl.step(1'b1, 1'b0, q);
      i_ctl.step(1'b1, 1'b0, q);
      exp_id = ID;
      note_port(16'h0001, `JTG_OP_IDCODE, 1'b0, 1'b0);
      $display("Select-IR exit done");
      i_ctl.step(1'b0, 1'b0, q);
      scan(1'b1, {193'h0, `JTG_OP_EXTEST}, 3, 1'b0);
      note_scan(256'h1, 3);
      note_port(16'h0002, `JTG_OP_EXTEST, 1'b1, 1'b0);
      trst_n = 1'b0;
      exp_bsr = 196'h0;
      note_port(16'h0001, `JTG_OP_IDCODE, 1'b0, 1'b0);
      trst_n = 1'b1;
      i_ctl.step(1'b0, 1'b0, q);
      note_port(16'h0002, `JTG_OP_IDCODE, 1'b0, 1'b0);
      $display("Test reset done");
      wrap_up;
   end
endmodule
